// >>> logic/osr_top.sv
// fuse array controller with power-up loaded security register
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module osr_top
    import osr_pkg::*;
#(
    parameter int ROWS = OSR_ROWS,
    parameter int SECTORS = OSR_SECTORS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dbg_req,
    input wire logic dbg_fuse_req,
    input wire logic dbg_fuse_we,
    input wire logic link_req,
    output osr_pkg::osr_gate_s gate,
    output logic dbg_grant,
    output logic dbg_fuse_grant,
    output logic link_grant,
    output logic core_run,
    output logic [31:0] boot_addr,
    output logic copy_valid,
    output logic [10:0] copy_addr,
    output logic [31:0] copy_data,
    output logic [31:0] user_code
);
    import osr_pkg::*;

    localparam int DEPTH = ROWS * SECTORS;
    localparam int AW = $clog2(DEPTH);

    // ======================================================
    // fuse storage, flops indexed by row; bits only ever go 0 -> 1
    // a blank array powers up all zero; contents survive every later reset
    logic [OSR_ROW_W-1:0] fuse_mem [DEPTH] = '{default: '0};
    logic [15:0] addr_port_reg;
    logic [31:0] data_port_reg;
    logic [15:0] ctrl_port_reg;
    logic [31:0] sec_reg;
    logic [31:0] rdata_reg;
    logic dropped_reg;
    logic done_reg;
    osr_state_e state_reg;
    logic [AW-1:0] ptr_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;

    // sector of a row address: top bits above the in-sector row index
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        sector_of = a[OSR_ROW_AW +: 2];
    endfunction

    // a programming request is refused if its sector or the whole array is locked
    function automatic logic prog_locked(input logic [31:0] s, input logic [15:0] a);
        prog_locked = s[OSR_B_MLOCK] | s[OSR_B_LOCK0 + 32'(sector_of(a))];
    endfunction

    // ======================================================
    // bus write capture: address and data may come in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    wire [7:0] wa = awaddr_reg;
    wire busy = (state_reg != OSR_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_hold_reg & ~aw_take;
            s_axi_wready <= ~w_hold_reg & ~w_take;
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_reg <= 1'b0;
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end else if (wr_go) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // write response; unmapped offsets answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OSR_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa == OSR_OFF_ADDR || wa == OSR_OFF_DATA || wa == OSR_OFF_CTRL)
                ? OSR_RESP_OKAY : OSR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ======================================================
    // dedicated programming ports, whole-word writes only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_port_reg <= 16'h0000;
            data_port_reg <= 32'h0000_0000;
            ctrl_port_reg <= 16'h0000;
        end else begin
            if (wr_go && wa == OSR_OFF_ADDR) begin
                addr_port_reg <= wdata_reg[15:0];
            end
            if (wr_go && wa == OSR_OFF_DATA) begin
                data_port_reg <= wdata_reg;
            end
            // command self-clears only once the engine has acted on it,
            // so the prog state still sees which command it serves
            if (wr_go && wa == OSR_OFF_CTRL) begin
                ctrl_port_reg <= wdata_reg[15:0];
            end else if (state_reg == OSR_PROG || state_reg == OSR_READ) begin
                ctrl_port_reg <= 16'h0000;
            end else if (state_reg == OSR_IDLE && !(cmd_prog || cmd_secw || cmd_read)) begin
                ctrl_port_reg <= 16'h0000;
            end
        end
    end

    // ======================================================
    // engine: load security word, copy image, then serve commands
    wire [AW-1:0] cmd_row = addr_port_reg[AW-1:0];
    wire cmd_prog = (ctrl_port_reg == OSR_CMD_PROG);
    wire cmd_read = (ctrl_port_reg == OSR_CMD_READ);
    wire cmd_secw = (ctrl_port_reg == OSR_CMD_SECW);
    wire cmd_gpw = (ctrl_port_reg == OSR_CMD_GPW);
    wire row_ok = ({16'h0000, addr_port_reg} < 32'(DEPTH));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= OSR_LOAD_SEC;
            ptr_reg <= '0;
            sec_reg <= OSR_SEC_RST;
            done_reg <= 1'b0;
            dropped_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            copy_valid <= 1'b0;
            copy_addr <= 11'h000;
            copy_data <= 32'h0000_0000;
        end else begin
            copy_valid <= 1'b0;
            case (state_reg)
                OSR_LOAD_SEC: begin
                    sec_reg <= fuse_mem[OSR_SEC_ROW[AW-1:0]];
                    state_reg <= OSR_COPY;
                end
                OSR_COPY: begin
                    // security row is excluded from the image
                    copy_valid <= (ptr_reg != OSR_SEC_ROW[AW-1:0]);
                    copy_addr <= 11'(ptr_reg);
                    copy_data <= fuse_mem[ptr_reg];
                    ptr_reg <= ptr_reg + 1'b1;
                    if (ptr_reg == AW'(DEPTH - 1)) begin
                        state_reg <= OSR_IDLE;
                        done_reg <= 1'b1;
                    end
                end
                OSR_IDLE: begin
                    if (cmd_prog || cmd_secw) begin
                        state_reg <= OSR_PROG;
                    end else if (cmd_read) begin
                        state_reg <= OSR_READ;
                    end else if (cmd_gpw) begin
                        // software field is freely writable, no fuse burn
                        sec_reg[OSR_GP_HI:OSR_GP_LO] <= data_port_reg[OSR_GP_HI:OSR_GP_LO];
                    end
                end
                OSR_PROG: begin
                    if (sec_reg[OSR_B_MLOCK] ||
                        (cmd_prog && (!row_ok || prog_locked(sec_reg, addr_port_reg)))) begin
                        dropped_reg <= 1'b1;
                    end else if (cmd_secw) begin
                        sec_reg <= sec_reg | data_port_reg;
                    end
                    state_reg <= OSR_IDLE;
                end
                OSR_READ: begin
                    rdata_reg <= row_ok ? fuse_mem[cmd_row] : 32'h0000_0000;
                    state_reg <= OSR_IDLE;
                end
                default: state_reg <= OSR_IDLE;
            endcase
        end
    end

    // fuse bits burn in place; blank array is all zero; no reset of contents
    always_ff @(posedge aclk) begin
        if (state_reg == OSR_PROG && !sec_reg[OSR_B_MLOCK]) begin
            if (cmd_prog && row_ok && !prog_locked(sec_reg, addr_port_reg)) begin
                fuse_mem[cmd_row] <= fuse_mem[cmd_row] | data_port_reg;
            end else if (cmd_secw) begin
                fuse_mem[OSR_SEC_ROW[AW-1:0]] <= fuse_mem[OSR_SEC_ROW[AW-1:0]]
                    | data_port_reg;
            end
        end
    end

    // ======================================================
    // bus reads: one outstanding, answered the cycle after acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= OSR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= OSR_RESP_OKAY;
                case (s_axi_araddr)
                    OSR_OFF_ADDR: s_axi_rdata <= {16'h0000, addr_port_reg};
                    OSR_OFF_DATA: s_axi_rdata <= data_port_reg;
                    OSR_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_port_reg};
                    OSR_OFF_SEC: s_axi_rdata <= sec_reg;
                    OSR_OFF_STAT: s_axi_rdata <= {29'h0, dropped_reg, busy, done_reg};
                    OSR_OFF_RDATA: s_axi_rdata <= rdata_reg;
                    OSR_OFF_USER: s_axi_rdata <= user_code;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= OSR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ======================================================
    // security gates; grants held low until the image copy is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate <= '0;
            dbg_grant <= 1'b0;
            dbg_fuse_grant <= 1'b0;
            link_grant <= 1'b0;
            core_run <= 1'b0;
            boot_addr <= 32'h0000_0000;
            user_code <= 32'h0000_0000;
        end else begin
            gate.dbg_block <= sec_reg[OSR_B_NODBG];
            gate.link_block <= sec_reg[OSR_B_NOLINK];
            gate.boot_fuse <= sec_reg[OSR_B_SBOOT];
            gate.spare_en <= sec_reg[OSR_B_SPARE];
            gate.dbg_fuse_block <= sec_reg[OSR_B_NODBGF];
            dbg_grant <= done_reg & dbg_req & ~sec_reg[OSR_B_NODBG];
            link_grant <= done_reg & link_req & ~sec_reg[OSR_B_NOLINK];
            // writes need the master lock clear as well
            dbg_fuse_grant <= done_reg & dbg_fuse_req & ~sec_reg[OSR_B_NODBG]
                & ~sec_reg[OSR_B_NODBGF] & ~(dbg_fuse_we & sec_reg[OSR_B_MLOCK]);
            core_run <= done_reg;
            boot_addr <= 32'h0000_0000;
            user_code <= {sec_reg[OSR_UID_HI:OSR_UID_LO], 6'h00, OSR_SILICON_REV};
        end
    end
endmodule

// >>> common/osr_pkg.sv
// shared constants and types for the fuse controller and security register
package osr_pkg;
    // ======================================================
    // array geometry
    localparam int OSR_SECTORS = 4;
    localparam int OSR_ROWS = 512;
    localparam int OSR_ROW_W = 32;
    localparam int OSR_ROW_AW = 9;
    localparam int OSR_AW = 11;
    // ======================================================
    // dedicated port resource numbers and widths
    localparam logic [23:0] OSR_RES_ADDR = 24'h100200;
    localparam logic [23:0] OSR_RES_DATA = 24'h200100;
    localparam logic [23:0] OSR_RES_CTRL = 24'h100300;
    localparam int OSR_ADDR_PW = 16;
    localparam int OSR_CTRL_PW = 16;
    // ======================================================
    // register byte offsets on the bus
    localparam logic [7:0] OSR_OFF_ADDR = 8'h00;
    localparam logic [7:0] OSR_OFF_DATA = 8'h04;
    localparam logic [7:0] OSR_OFF_CTRL = 8'h08;
    localparam logic [7:0] OSR_OFF_SEC = 8'h0c;
    localparam logic [7:0] OSR_OFF_STAT = 8'h10;
    localparam logic [7:0] OSR_OFF_RDATA = 8'h14;
    localparam logic [7:0] OSR_OFF_USER = 8'h18;
    // ======================================================
    // security bit positions
    localparam int OSR_B_NODBG = 0;
    localparam int OSR_B_NOLINK = 1;
    localparam int OSR_B_SBOOT = 5;
    localparam int OSR_B_SPARE = 7;
    localparam int OSR_B_LOCK0 = 8;
    localparam int OSR_B_MLOCK = 12;
    localparam int OSR_B_NODBGF = 13;
    localparam int OSR_GP_LO = 15;
    localparam int OSR_GP_HI = 21;
    localparam int OSR_UID_LO = 22;
    localparam int OSR_UID_HI = 31;
    // ======================================================
    // control port codes and values after reset
    localparam logic [15:0] OSR_CMD_PROG = 16'h0001;
    localparam logic [15:0] OSR_CMD_READ = 16'h0002;
    localparam logic [15:0] OSR_CMD_SECW = 16'h0004;
    localparam logic [15:0] OSR_CMD_GPW = 16'h0008;
    localparam logic [31:0] OSR_SEC_RST = 32'h0000_0000;
    localparam logic [10:0] OSR_SEC_ROW = 11'h7ff;
    localparam logic [15:0] OSR_SILICON_REV = 16'h0001; // arbitrary value
    // ======================================================
    // bus response codes
    localparam logic [1:0] OSR_RESP_OKAY = 2'b00;
    localparam logic [1:0] OSR_RESP_SLVERR = 2'b10;

    // access gates derived from the security word
    typedef struct packed {
        logic dbg_block;
        logic link_block;
        logic boot_fuse;
        logic spare_en;
        logic dbg_fuse_block;
    } osr_gate_s;

    typedef enum logic [4:0] {
        OSR_LOAD_SEC = 5'b00001,
        OSR_COPY = 5'b00010,
        OSR_IDLE = 5'b00100,
        OSR_PROG = 5'b01000,
        OSR_READ = 5'b10000
    } osr_state_e;
endpackage

// >>> verif/osr_top_monitor.sv
// port checker for the fuse controller and security register
`timescale 1ns/10ps
module osr_top_monitor
    import osr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dbg_req,
    input wire logic link_req,
    input wire logic dbg_fuse_req,
    input wire osr_pkg::osr_gate_s gate,
    input wire logic dbg_grant,
    input wire logic link_grant,
    input wire logic dbg_fuse_grant,
    input wire logic core_run,
    input wire logic [31:0] boot_addr,
    input wire logic copy_valid,
    input wire logic [10:0] copy_addr,
    input wire logic [31:0] user_code
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ======================================================
    // access gates: a grant needs a request and no settled block bit
    property p_dbg;
        dbg_grant |-> $past(dbg_req) && !gate.dbg_block;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug grant while blocked");
    property p_link;
        link_grant |-> $past(link_req) && !gate.link_block;
    endproperty
    a_link: assert property (p_link) else $error("switch grant while blocked");
    property p_dfuse;
        dbg_fuse_grant |-> $past(dbg_fuse_req)
            && !gate.dbg_fuse_block && !gate.dbg_block;
    endproperty
    a_dfuse: assert property (p_dfuse) else $error("debug fuse grant while blocked");
    // ======================================================
    // start address and user code
    property p_boot;
        core_run |-> boot_addr == 32'h0;
    endproperty
    a_boot: assert property (p_boot) else $error("start address not zero");
    property p_user;
        core_run |-> user_code[21:0] == {6'h0, OSR_SILICON_REV};
    endproperty
    a_user: assert property (p_user) else $error("user code low part wrong");
    // ======================================================
    // image copy: rows in order, security row kept out, core held meanwhile
    property p_cseq;
        copy_valid ##1 copy_valid |-> copy_addr == $past(copy_addr) + 11'h1;
    endproperty
    a_cseq: assert property (p_cseq) else $error("copy rows out of order");
    property p_crun;
        copy_valid |-> !core_run;
    endproperty
    a_crun: assert property (p_crun) else $error("core running during copy");
    property p_srow;
        copy_valid |-> copy_addr != OSR_SEC_ROW;
    endproperty
    a_srow: assert property (p_srow) else $error("security row copied");
    property p_run;
        core_run |=> core_run;
    endproperty
    a_run: assert property (p_run) else $error("core stopped after start");
endmodule

// >>> verif/osr_cpu_model.sv
// processor-side bus model issuing register reads and writes
`timescale 1ns/10ps
module osr_cpu_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int slow = 0; // extra cycles before taking an answer
    // quiet bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // ======================================================
    // write: address and word offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a; // stale address must not look valid
                ad = 1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
                wd = 1;
            end
        end
        repeat (slow) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // read: one outstanding, answer taken at the rready edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (slow) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the fuse controller and security register
`timescale 1ns/10ps
module testbench;
    import osr_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic dbg_req, dbg_fuse_req, dbg_fuse_we, link_req, dbg_grant, dbg_fuse_grant, link_grant;
    logic core_run, copy_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [10:0] copy_addr;
    logic [31:0] s_axi_wdata, s_axi_rdata, boot_addr, copy_data, user_code, d;
    osr_gate_s gate;
    int bad_count = 0;
    int checks = 0;
    int ncopy = 0;
    logic [31:0] row5 = 32'h0;
    osr_top osr_top_i (.*);
    osr_cpu_model osr_cpu_model_i (.*);
    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // count rows streamed out at power up
    always @(posedge aclk) begin
        if (aresetn && copy_valid) begin
            ncopy++;
            if (copy_addr == 11'd5) row5 = copy_data;
        end
    end
    // ======================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // command through the three ports, then wait for the engine to go idle
    task automatic prog(input logic [15:0] row, input logic [31:0] v, input logic [15:0] cmd);
        osr_cpu_model_i.wr(OSR_OFF_ADDR, {16'h0, row}, r);
        osr_cpu_model_i.wr(OSR_OFF_DATA, v, r);
        osr_cpu_model_i.wr(OSR_OFF_CTRL, {16'h0, cmd}, r);
        for (int n = 0; n < 40; n++) begin
            osr_cpu_model_i.rd(OSR_OFF_STAT, d, r);
            if (d[1] === 1'b0) break;
        end
    endtask
    task automatic rrow(input logic [15:0] row, input logic [31:0] exp);
        prog(row, 32'h0, OSR_CMD_READ);
        osr_cpu_model_i.rd(OSR_OFF_RDATA, d, r);
        chk(d, exp);
    endtask
    task automatic sec_is(input logic [31:0] exp);
        osr_cpu_model_i.rd(OSR_OFF_SEC, d, r);
        chk(d, exp);
    endtask
    // ======================================================
    // scenarios
    task automatic t_boot;
        for (int n = 0; n < 3000 && core_run !== 1'b1; n++) @(posedge aclk);
        @(negedge aclk);
        chk(ncopy, 32'd2047);
        chk(row5, 32'h0);
        chk(boot_addr, 32'h0);
        chk(user_code, {16'h0, OSR_SILICON_REV});
        chk({27'h0, gate}, 32'h0);
        chk({29'h0, dbg_grant, link_grant, dbg_fuse_grant}, 32'h7);
        @(posedge aclk);
        sec_is(OSR_SEC_RST);
        $display("test boot done");
    endtask
    task automatic t_prog;
        prog(16'd5, 32'ha5a5_0f0f, OSR_CMD_PROG);
        rrow(16'd5, 32'ha5a5_0f0f);
        prog(16'd1536, 32'h0000_0001, OSR_CMD_PROG);
        rrow(16'd1536, 32'h0000_0001);
        osr_cpu_model_i.rd(OSR_OFF_STAT, d, r);
        chk({31'h0, d[2]}, 32'h0);
        prog(16'h0800, 32'hffff_ffff, OSR_CMD_PROG);
        chk({31'h0, d[2]}, 32'h1);
        $display("test prog done");
    endtask
    task automatic t_lock;
        prog(16'h0, 32'ha940_25a3, OSR_CMD_SECW);
        sec_is(32'ha940_25a3);
        @(negedge aclk);
        chk({27'h0, gate}, 32'h1f);
        chk({29'h0, dbg_grant, link_grant, dbg_fuse_grant}, 32'h0);
        chk(user_code, 32'ha940_0001);
        @(posedge aclk);
        prog(16'd5, 32'hffff_ffff, OSR_CMD_PROG);
        rrow(16'd5, 32'ha5a5_0f0f);
        prog(16'd1100, 32'hffff_ffff, OSR_CMD_PROG);
        rrow(16'd1100, 32'h0);
        prog(16'd600, 32'h1234_5678, OSR_CMD_PROG);
        rrow(16'd600, 32'h1234_5678);
        prog(16'h0, 32'h003f_8000, OSR_CMD_GPW);
        sec_is(32'ha97f_a5a3);
        $display("test lock done");
    endtask
    task automatic t_mlock;
        prog(16'h0, 32'h0000_1000, OSR_CMD_SECW);
        prog(16'd700, 32'h0000_ffff, OSR_CMD_PROG);
        rrow(16'd700, 32'h0);
        prog(16'h0, 32'h0000_0200, OSR_CMD_SECW);
        sec_is(32'ha97f_b5a3);
        $display("test master lock done");
    endtask
    task automatic t_bus;
        osr_cpu_model_i.slow = 3;
        osr_cpu_model_i.rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, OSR_RESP_SLVERR});
        osr_cpu_model_i.wr(8'h40, 32'h1, r);
        chk({30'h0, r}, {30'h0, OSR_RESP_SLVERR});
        osr_cpu_model_i.wr(OSR_OFF_SEC, 32'h0, r);
        chk({30'h0, r}, {30'h0, OSR_RESP_SLVERR});
        sec_is(32'ha97f_b5a3);
        $display("test bus done");
    endtask
    // second reset: security word must come back from the burned row
    task automatic t_rst;
        int n0;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        n0 = ncopy;
        aresetn <= 1'b1;
        for (int n = 0; n < 3000 && core_run !== 1'b1; n++) @(posedge aclk);
        @(posedge aclk);
        chk(ncopy - n0, 32'd2047);
        chk(row5, 32'ha5a5_0f0f);
        sec_is(32'ha940_35a3);
        osr_cpu_model_i.rd(OSR_OFF_STAT, d, r);
        chk(d, 32'h1);
        $display("test reset done");
    endtask
    // ======================================================
    // main sequence
    initial begin
        aresetn = 1'b0;
        {dbg_req, dbg_fuse_req, dbg_fuse_we, link_req} = 4'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        dbg_req <= 1'b1;
        link_req <= 1'b1;
        dbg_fuse_req <= 1'b1;
        t_boot;
        t_prog;
        t_lock;
        t_mlock;
        t_bus;
        t_rst;
        final_report;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report;
    end
endmodule
bind osr_top osr_top_monitor osr_top_monitor_i (.*);
